// [bemf_sampling_capture.sv]
// Rotor-position sampling and commutation-timer capture with a Wishbone slave.
// Assumes motor_pwm_output and commutation_timer come from sys_clk logic.
`timescale 1ns/1ps
`include "bemf_sampling_defs.svh"

// Functional notes
// - Hold off sampling 3 us after enabling.
// - Tacho capture on second clock after change.
// - Off-time zero capture three clocks after PWM on.
// - Off-time sensor state one clock after PWM on.
// - Sampling-clock zero event: tick plus three clocks.
// - Demag event and capture: tick plus three clocks.
// - On-time zero event: delay plus three clocks.
// - On-time with sampling clock: delay, tick, three.
// - Input select flags in one clock; settle.
// - Sampling clock divides by 4, 8, 16, 32.
// - Reference level codes 000 to 110 only.
module bemf_sampling_capture
#(
  parameter int TIMER_W = 16,
  parameter int DELAY_W = 8
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               ce,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [3:0]         rotor_sense_input,
  input  wire logic               demag_comp_input,
  input  wire logic               motor_pwm_output,
  input  wire logic [TIMER_W-1:0] commutation_timer,
  output logic                    comparator_enable,
  output logic [2:0]              reference_level_out,
  output logic [1:0]              input_select_out,
  output logic [3:0]              selected_input_flag,
  output logic                    sensor_state_bit,
  output logic                    zero_cross_event,
  output logic                    demag_event,
  output logic                    irq
);
  import bemf_sampling_pkg::*;

  localparam int STARTUP_CYC = `STARTUP_CYC;
  localparam int SETTLE_CYC  = `SETTLE_CYC;

  // Refuse widths the 32-bit bus cannot carry
  if (TIMER_W < 1 || TIMER_W > 32 || DELAY_W < 1 || DELAY_W > 16)
  begin : g_check
    $error("bemf_sampling_capture: TIMER_W or DELAY_W out of range");
  end

  ctrl_t                ctrl;
  logic [DELAY_W-1:0]   sample_delay_field;
  logic [TIMER_W-1:0]   zero_cross_capture;
  logic [TIMER_W-1:0]   demag_capture;
  logic [`IRQ_W-1:0]    irq_status;
  logic [`IRQ_W-1:0]    irq_mask;
  logic [`IRQ_W-1:0]    irq_set;
  logic [1:0]           input_select_field;
  logic [4:0]           sync_lvl;
  logic                 tacho_prev;
  logic                 demag_prev;
  logic                 pwm_prev;
  logic [7:0]           start_cnt;
  logic [2:0]           settle_cnt;
  logic [DELAY_W-1:0]   delay_cnt;
  logic [4:0]           div_cnt;
  logic                 ready;
  sampler_state_t       st;
  sampler_state_t       next_st;
  evt_t                 pipe1;
  evt_t                 pipe2;
  logic                 bus_req;
  logic                 bus_wr;
  logic                 ph_write;
  logic                 enabled;
  logic                 pwm_rise;
  logic                 tick;
  logic                 take;
  logic                 sel_val;
  logic                 tacho_chg;
  logic [4:0]           div_mask;

  // Comparator levels are asynchronous to sys_clk
  input_sync #(
    .WIDTH (5)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .async_in ({demag_comp_input, rotor_sense_input}),
    .sync_out (sync_lvl)
  );

  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
  assign ph_write  = bus_wr && (wb_adr_i == `OFS_PHASE_STATE);
  assign enabled   = ctrl.comp_on || ctrl.ref_on;
  assign pwm_rise  = motor_pwm_output && !pwm_prev;
  assign sel_val   = sync_lvl[input_select_field];
  assign tacho_chg = ready && (ctrl.mode == MODE_TACHO) && (sel_val != tacho_prev);

  // Sampling clock as an enable: divide by 4 << select
  assign div_mask = 5'h1F >> (2'd3 - ctrl.sample_clock_select);
  assign tick     = ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      div_cnt <= 5'h00;
    else if (ce)
      div_cnt <= div_cnt + 5'h01;
  end

  // Control register; a reserved reference code leaves the old level in place
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ctrl <= ctrl_t'(`CTRL_RESET);
    else if (ce && bus_wr && wb_adr_i == `OFS_CONTROL && wb_sel_i[1])
    begin
      ctrl <= ctrl_t'(wb_dat_i[`CTRL_W-1:0]);
      if (wb_dat_i[9:7] == `REF_LEVEL_ILLEGAL)
        ctrl.reference_level_select <= ctrl.reference_level_select;
    end
  end

  // Sample delay and input select
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sample_delay_field  <= DELAY_W'(`DELAY_RESET);
      input_select_field  <= 2'b00;
      selected_input_flag <= 4'h1;
    end
    else if (ce)
    begin
      if (bus_wr && wb_adr_i == `OFS_SAMPLE_DELAY)
        sample_delay_field <= wb_dat_i[DELAY_W-1:0];
      if (ph_write)
      begin
        input_select_field  <= wb_dat_i[1:0];
        selected_input_flag <= 4'h1 << wb_dat_i[1:0];
      end
    end
  end

  // Analog mux settling after a new input is chosen
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      settle_cnt <= 3'h0;
    else if (ce)
    begin
      if (ph_write)
        settle_cnt <= 3'(SETTLE_CYC);
      else if (settle_cnt != 3'h0)
        settle_cnt <= settle_cnt - 3'h1;
    end
  end

  // Start-up filter; restarts whenever both enables go low
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      start_cnt <= 8'(STARTUP_CYC);
      ready     <= 1'b0;
    end
    else if (ce)
    begin
      if (!enabled)
      begin
        start_cnt <= 8'(STARTUP_CYC);
        ready     <= 1'b0;
      end
      else if (start_cnt > 8'h01)
        start_cnt <= start_cnt - 8'h01;
      else
        ready <= 1'b1;
    end
  end

  // Sampler sequencing
  always_comb
  begin
    next_st = st;
    take    = 1'b0;
    unique case (st)
      ST_START:
        if (ready)
          next_st = ST_IDLE;
      ST_IDLE:
        if (settle_cnt == 3'h0)
        begin
          unique case (ctrl.mode)
            MODE_OFF_TIME: take = pwm_rise;
            MODE_SCLK:     take = tick;
            MODE_ON_DELAY:
              if (pwm_rise)
              begin
                if (sample_delay_field == '0)
                  take = 1'b1;
                else
                  next_st = ST_DELAY;
              end
            MODE_TACHO:    take = 1'b0;
          endcase
        end
      ST_DELAY:
        if (delay_cnt == DELAY_W'(1))
        begin
          if (ctrl.delay_at_sclk)
            next_st = ST_TICK;
          else
          begin
            take    = 1'b1;
            next_st = ST_IDLE;
          end
        end
      ST_TICK:
        if (tick)
        begin
          take    = 1'b1;
          next_st = ST_IDLE;
        end
    endcase
    if (!ready)
    begin
      next_st = ST_START;
      take    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st        <= ST_START;
      delay_cnt <= '0;
      pwm_prev  <= 1'b0;
    end
    else if (ce)
    begin
      st       <= next_st;
      pwm_prev <= motor_pwm_output;
      if (st == ST_IDLE && next_st == ST_DELAY)
        delay_cnt <= sample_delay_field;
      else if (delay_cnt != '0)
        delay_cnt <= delay_cnt - DELAY_W'(1);
    end
  end

  // Sensor state one clock after the sample; tacho follows the input directly
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sensor_state_bit <= 1'b0;
      tacho_prev       <= 1'b0;
      demag_prev       <= 1'b0;
    end
    else if (ce)
    begin
      tacho_prev <= sel_val;
      if (take)
        sensor_state_bit <= sel_val;
      if (ready && tick)
        demag_prev <= sync_lvl[4];
    end
  end

  // Latency pipe: two stages for zero and demag, capture on the third edge; tacho uses one stage, capture on the second
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pipe1 <= '0;
      pipe2 <= '0;
    end
    else if (ce)
    begin
      pipe1.zero  <= take && (sel_val != sensor_state_bit);
      pipe1.demag <= ready && tick && (sync_lvl[4] != demag_prev);
      pipe1.tacho <= tacho_chg;
      pipe2.zero  <= pipe1.zero;
      pipe2.demag <= pipe1.demag;
      pipe2.tacho <= 1'b0;
    end
  end

  // Timer captures and event pulses
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      zero_cross_capture <= '0;
      demag_capture      <= '0;
      zero_cross_event   <= 1'b0;
      demag_event        <= 1'b0;
    end
    else if (ce)
    begin
      zero_cross_event <= pipe2.zero;
      demag_event      <= pipe2.demag;
      if (pipe2.zero || pipe1.tacho)
        zero_cross_capture <= commutation_timer;
      if (pipe2.demag)
        demag_capture <= commutation_timer;
    end
  end

  // Sticky status; a new event beats a write-one clear
  // Ready source pulses once, in the cycle before ready rises, so a clear sticks
  assign irq_set = {enabled && !ready && start_cnt == 8'h01, pipe1.tacho, pipe2.demag,
                    pipe2.zero};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end
    else if (ce)
    begin
      if (bus_wr && wb_adr_i == `OFS_IRQ_STATUS)
        irq_status <= (irq_status & ~wb_dat_i[`IRQ_W-1:0]) | irq_set;
      else
        irq_status <= irq_status | irq_set;
      if (bus_wr && wb_adr_i == `OFS_IRQ_MASK)
        irq_mask <= wb_dat_i[`IRQ_W-1:0];
      irq <= |(irq_status & irq_mask);
    end
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          `OFS_CONTROL:       wb_dat_o <= 32'(ctrl);
          `OFS_PHASE_STATE:   wb_dat_o <= {22'h0, ready, sensor_state_bit, 2'b00,
                                           selected_input_flag, input_select_field};
          `OFS_SAMPLE_DELAY:  wb_dat_o <= 32'(sample_delay_field);
          `OFS_ZERO_CAPTURE:  wb_dat_o <= 32'(zero_cross_capture);
          `OFS_DEMAG_CAPTURE: wb_dat_o <= 32'(demag_capture);
          `OFS_IRQ_STATUS:    wb_dat_o <= 32'(irq_status);
          `OFS_IRQ_MASK:      wb_dat_o <= 32'(irq_mask);
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Analog-facing controls
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      comparator_enable   <= 1'b0;
      reference_level_out <= 3'h0;
      input_select_out    <= 2'b00;
    end
    else if (ce)
    begin
      comparator_enable   <= enabled;
      reference_level_out <= ctrl.reference_level_select;
      input_select_out    <= input_select_field;
    end
  end

  // Helpers for assertions: cycles since enable and since rise
  logic [8:0]         en_age;
  logic [DELAY_W:0]   rise_age;
  always_ff @(posedge sys_clk)
  begin
    if (reset || !enabled)
      en_age <= 9'h000;
    else if (ce && en_age != 9'h1FF)
      en_age <= en_age + 9'h001;
    if (reset || pwm_rise)
      rise_age <= '0;
    else if (ce)
      rise_age <= rise_age + (DELAY_W+1)'(1);
  end

  sequence s_zero_take;
    take && (sel_val != sensor_state_bit);
  endsequence

  sequence s_zero_done;
    ##3 zero_cross_event;
  endsequence

  a_startup_hold: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    $rose(ready) |-> en_age >= 9'(STARTUP_CYC - 1))
    else $error("ready before start-up time");
  a_tacho_capture: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    tacho_chg |-> ##2 zero_cross_capture == $past(commutation_timer))
    else $error("tacho capture late or wrong");
  a_off_zero: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    (ctrl.mode == MODE_OFF_TIME) and s_zero_take |-> s_zero_done)
    else $error("off-time zero event not at third clock");
  a_state_update: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    take |=> sensor_state_bit == $past(sel_val))
    else $error("sensor state not updated");
  a_sclk_zero: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    (ctrl.mode == MODE_SCLK) and s_zero_take |-> tick ##3 zero_cross_event)
    else $error("sampling-clock zero event misplaced");
  a_demag_capture: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    ready && tick && sync_lvl[4] != demag_prev |-> ##3 demag_event
      && demag_capture == $past(commutation_timer))
    else $error("demag event misplaced");
  a_delay_take: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    take && st == ST_DELAY |-> rise_age + (DELAY_W+1)'(1) == (DELAY_W+1)'(sample_delay_field))
    else $error("on-time sample not after delay");
  a_tick_take: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    take && st == ST_TICK |-> tick && rise_age >= (DELAY_W+1)'(sample_delay_field))
    else $error("delayed sclk sample off tick");
  a_input_flag: assert property (@(posedge sys_clk) disable iff (reset || !ce)
    ph_write |=> selected_input_flag == (4'h1 << $past(wb_dat_i[1:0])))
    else $error("input flag not set in one clock");
  a_ref_legal: assert property (@(posedge sys_clk) disable iff (reset)
    reference_level_out != `REF_LEVEL_ILLEGAL)
    else $error("reserved reference level driven");

endmodule

// [bemf_sampling_defs.svh]
// Offsets, field positions, reset values and timing counts of the sampling block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef BEMF_SAMPLING_DEFS_SVH
`define BEMF_SAMPLING_DEFS_SVH

// Register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_PHASE_STATE    8'h04
`define OFS_SAMPLE_DELAY   8'h08
`define OFS_ZERO_CAPTURE   8'h0C
`define OFS_DEMAG_CAPTURE  8'h10
`define OFS_IRQ_STATUS     8'h14
`define OFS_IRQ_MASK       8'h18

// Field positions
`define CTRL_W             10
`define PH_FLAG_LSB        2
`define PH_STATE_BIT       8
`define PH_READY_BIT       9
`define IRQ_W              4
`define IRQ_ZERO           0
`define IRQ_DEMAG          1
`define IRQ_TACHO          2
`define IRQ_READY          3

// Reset values and the reserved reference code
`define CTRL_RESET         10'h000
`define DELAY_RESET        8'h00
`define REF_LEVEL_ILLEGAL  3'h7

// Timing
`define SYS_CLK_MHZ        40
`define STARTUP_NS         3000
`define STARTUP_CYC        ((`STARTUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SETTLE_NS          100
`define SETTLE_CYC         ((`SETTLE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define DIV_BASE_LOG2      2

`endif

// [bemf_sampling_pkg.sv]
// Types shared by the sampling block: modes, sampler states and carriers.
// Assumes the constants header is included by the modules that need numbers.
package bemf_sampling_pkg;

  typedef enum logic [1:0] {
    MODE_OFF_TIME = 2'b00,
    MODE_SCLK     = 2'b01,
    MODE_ON_DELAY = 2'b10,
    MODE_TACHO    = 2'b11
  } sample_mode_t;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_IDLE  = 2'b01,
    ST_DELAY = 2'b11,
    ST_TICK  = 2'b10
  } sampler_state_t;

  // Control word as it sits in the control register
  typedef struct packed {
    logic [2:0]   reference_level_select;
    logic [1:0]   sample_clock_select;
    logic         delay_at_sclk;
    sample_mode_t mode;
    logic         ref_on;
    logic         comp_on;
  } ctrl_t;

  // Pending event travelling down the latency pipe
  typedef struct packed {
    logic zero;
    logic demag;
    logic tacho;
  } evt_t;

endpackage

// [input_sync.sv]
// Two-stage synchroniser for a group of asynchronous comparator levels.
// Assumes levels change slowly compared with the clock; no pulse capture.
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [comparator_model.sv]
// Behavioural model of the phase and demagnetisation comparators.
// Assumes the bench sets the phase levels seen against the reference.
`timescale 1ns/1ps
module comparator_model (
  input  wire logic       sys_clk,
  input  wire logic       comparator_enable,
  input  wire logic [2:0] reference_level_out,
  input  wire logic [3:0] phase_level,
  input  wire logic       demag_level,
  output logic      [3:0] rotor_sense_input,
  output logic            demag_comp_input
);
  initial rotor_sense_input = 4'h0;
  initial demag_comp_input = 1'b0;

  // Unpowered comparators chatter, so a premature sample sees junk
  always @(posedge sys_clk)
  begin
    if (comparator_enable && reference_level_out != 3'h7)
    begin
      rotor_sense_input <= phase_level;
      demag_comp_input  <= demag_level;
    end
    else
    begin
      rotor_sense_input <= ~rotor_sense_input;
      demag_comp_input  <= ~demag_comp_input;
    end
  end
endmodule

// [bemf_sampling_capture_bench.sv]
// Self-checking bench: Wishbone tasks, comparator model, free-running timer.
// Assumes the design and its package are compiled before this file.
`timescale 1ns/1ps
`include "bemf_sampling_defs.svh"
module bemf_sampling_capture_bench;
  import bemf_sampling_pkg::*;
  logic        sys_clk = 0, reset = 1, ce = 1, cyc = 0, stb = 0, we = 0, pwm = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, comparator_enable, sensor_state_bit, zero_cross_event;
  logic        demag_event, irq, demag_level = 0;
  logic [2:0]  reference_level_out;
  logic [1:0]  input_select_out;
  logic [3:0]  selected_input_flag, rotor_sense_input, phase_level = 4'h0;
  logic        demag_comp_input;
  logic [15:0] timer = 16'h0, stamp;
  int          err_count = 0, tests_run = 0, cycles = 0, n, t1;

  initial forever #12.5 sys_clk = ~sys_clk;
  // Timer stands in for the commutation counter
  always @(posedge sys_clk)
  begin
    timer  <= timer + 16'h1;
    cycles <= cycles + 1;
  end

  bemf_sampling_capture i_dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rotor_sense_input(rotor_sense_input),
    .demag_comp_input(demag_comp_input), .motor_pwm_output(pwm), .commutation_timer(timer),
    .comparator_enable(comparator_enable), .reference_level_out(reference_level_out),
    .input_select_out(input_select_out), .selected_input_flag(selected_input_flag),
    .sensor_state_bit(sensor_state_bit), .zero_cross_event(zero_cross_event),
    .demag_event(demag_event), .irq(irq));

  comparator_model i_comp (.sys_clk(sys_clk), .comparator_enable(comparator_enable),
    .reference_level_out(reference_level_out), .phase_level(phase_level),
    .demag_level(demag_level), .rotor_sense_input(rotor_sense_input),
    .demag_comp_input(demag_comp_input));

  // Classic cycle: request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      err_count++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    wb(0, a, 32'h0);
    chk(what, e, q);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait for a demag or zero event; n counts edges
  task automatic wait_ev(input logic demag);
    n = 0;
    do begin tick(1); n++; end
    while ((demag ? demag_event : zero_cross_event) !== 1'b1 && n < 200);
    chk("event seen", 32'h1, demag ? demag_event : zero_cross_event);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 0;
    rd(`OFS_CONTROL, 32'h0, "control reset");
    chk("comp off", 32'h0, comparator_enable);
    rd(`OFS_PHASE_STATE, 32'h4, "phase reset");
    wb(1, 8'h1C, 32'hFF);
    rd(8'h1C, 32'h0, "unmapped");
    $display("test reset done");
    wb(1, `OFS_CONTROL, 32'h301);
    tick(100);
    rd(`OFS_PHASE_STATE, 32'h4, "ready early");
    chk("comp enable", 32'h1, comparator_enable);
    tick(30);
    rd(`OFS_PHASE_STATE, 32'h204, "ready late");
    rd(`OFS_IRQ_STATUS, 32'h8, "ready status");
    wb(1, `OFS_CONTROL, 32'h381);
    tick(2);
    chk("ref kept", 32'h6, reference_level_out);
    wb(1, `OFS_PHASE_STATE, 32'h2);
    tick(2);
    chk("flag", 32'h4, selected_input_flag);
    chk("select", 32'h2, input_select_out);
    $display("test enable done");
    wb(1, `OFS_IRQ_STATUS, 32'hF);
    wb(1, `OFS_IRQ_MASK, 32'h1);
    phase_level <= 4'h4;
    tick(10); // Settle and analog delay before sampling
    @(posedge sys_clk);
    pwm <= 1;
    tick(1);
    chk("state", 32'h1, sensor_state_bit);
    tick(1);
    stamp = timer;
    tick(1);
    chk("off zero event", 32'h1, zero_cross_event);
    rd(`OFS_ZERO_CAPTURE, {16'h0, stamp}, "off capture");
    pwm <= 0;
    chk("irq set", 32'h1, irq);
    rd(`OFS_IRQ_STATUS, 32'h1, "status zero");
    wb(1, `OFS_IRQ_STATUS, 32'h1);
    tick(2);
    chk("irq clear", 32'h0, irq);
    $display("test off-time done");
    for (int k = 0; k < 4; k++)
    begin
      wb(1, `OFS_CONTROL, 32'h305 | (k << 5));
      repeat (8) @(posedge sys_clk);
      demag_level <= ~demag_level;
      phase_level[2] <= ~phase_level[2];
      wait_ev(1);
      chk("zero with demag", 32'h1, zero_cross_event);
      t1 = cycles;
      @(posedge sys_clk);
      demag_level <= ~demag_level;
      wait_ev(1);
      stamp = timer - 16'h1;
      chk("tick spacing", 32'h0, (cycles - t1) % (4 << k));
      chk("spacing bound", 32'h1, (cycles - t1) <= (8 << k));
      rd(`OFS_DEMAG_CAPTURE, {16'h0, stamp}, "demag capture");
    end
    $display("test sampling clock done");
    wb(1, `OFS_SAMPLE_DELAY, 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      wb(1, `OFS_CONTROL, k ? 32'h319 : 32'h309);
      phase_level[2] <= ~phase_level[2];
      tick(8);
      @(posedge sys_clk);
      pwm <= 1;
      wait_ev(0);
      @(posedge sys_clk);
      pwm <= 0;
      if (k == 0)
        chk("delay latency", 32'd8, n);
      else
        chk("delay tick latency", 32'h1, n >= 8 && n <= 12);
    end
    $display("test on-delay done");
    wb(1, `OFS_CONTROL, 32'h30D);
    wb(1, `OFS_IRQ_STATUS, 32'hF);
    wb(1, `OFS_IRQ_MASK, 32'h4);
    tick(4);
    @(posedge sys_clk);
    phase_level[2] <= ~phase_level[2];
    tick(5);
    chk("tacho early", 32'h0, irq);
    stamp = timer - 16'h1;
    tick(1);
    chk("tacho irq", 32'h1, irq);
    rd(`OFS_IRQ_STATUS, 32'h4, "tacho status");
    rd(`OFS_ZERO_CAPTURE, {16'h0, stamp}, "tacho capture");
    $display("test tacho done");
    conclude();
  end
endmodule
